//--- backlight_pkg.sv
// shared constants and types of the brightness path
`default_nettype none
package backlight_pkg;
   localparam int CODE_W = 11;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_BRT_CTRL = 8'h11;
   localparam logic [7:0] ADDR_BOOST = 8'h13;
   localparam logic [7:0] ADDR_AF_HIGH = 8'h15;
   localparam logic [7:0] ADDR_AF_LOW = 8'h16;
   localparam logic [7:0] ADDR_ADJ = 8'h17;
   localparam logic [7:0] ADDR_BRT_LOW = 8'h18;
   localparam logic [7:0] ADDR_BRT_HIGH = 8'h19;
   localparam logic [7:0] ADDR_STATUS = 8'h1A;
   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int CTRL_POL_BIT = 0;
   localparam int CTRL_RATE_LSB = 1;
   localparam int CTRL_MODE_LSB = 5;
   localparam int BOOST_MIN_IND_BIT = 4;
   localparam int BOOST_FREQ_BIT = 5;
   localparam int BOOST_SHIFT_BIT = 6;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] LOW_RESET = 3'h0;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int RAMP_BASE_NS = 1000;
   localparam int RAMP_BASE_CYCLES = (RAMP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADJ_MAX_NS = 50000;
   localparam int ADJ_MAX_CYCLES = ADJ_MAX_NS / CLK_PERIOD_NS;
   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_REG = 2'h0,
      MODE_PWM = 2'h1,
      MODE_MUL_RAMP = 2'h2,
      MODE_RAMP_MUL = 2'h3
   } bright_mode_t;
   typedef enum logic [2:0] {
      FREQ_250K = 3'h1,
      FREQ_500K = 3'h2,
      FREQ_1M = 3'h4
   } sw_freq_t;
   // full duty (all ones) leaves the code unchanged
   function automatic logic [CODE_W-1:0] scale_by_duty(input logic [CODE_W-1:0] code,
                                                      input logic [CODE_W-1:0] duty);
      logic [2*CODE_W:0] prod;
      prod = code * ({1'b0, duty} + {{CODE_W{1'b0}}, 1'b1});
      return prod[2*CODE_W-1:CODE_W];
   endfunction
endpackage
`default_nettype wire

//--- brightness_path.sv
// brightness source selection, backlight reduction and boost frequency choice
`default_nettype none
module brightness_path (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var logic [7:0] reg_rdata_q,
   // pins
   input wire logic pwm_in,
   input wire logic backlight_reduce_input,
   // mapper and boost controls
   output var logic [10:0] led_code_q,
   output var backlight_pkg::sw_freq_t sw_freq_q,
   output var logic freq_shift_q,
   output var logic dmax_half_q,
   output var logic min_inductor_q
);
   import backlight_pkg::*;
   if (ADJ_MAX_CYCLES < 1)
      $error("reduction deadline shorter than one cycle");
   // -------------------------------------------------------------
   // register file
   // -------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] boost_q, boost_d;
   logic [7:0] af_hi_q, af_hi_d;
   logic [7:0] af_lo_q, af_lo_d;
   logic [7:0] adj_q, adj_d;
   logic [2:0] low_q, low_d;
   logic [7:0] high_q, high_d;
   logic [10:0] reg_code_q, reg_code_d;
   logic [7:0] rdata_d;
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction
   always_comb
   begin
      ctrl_d = ctrl_q;
      boost_d = boost_q;
      af_hi_d = af_hi_q;
      af_lo_d = af_lo_q;
      adj_d = adj_q;
      low_d = low_q;
      high_d = high_q;
      reg_code_d = reg_code_q;
      if (reg_wr)
      begin
         if (hit(reg_addr, ADDR_BRT_CTRL))
            ctrl_d = reg_wdata;
         if (hit(reg_addr, ADDR_BOOST))
            boost_d = reg_wdata;
         if (hit(reg_addr, ADDR_AF_HIGH))
            af_hi_d = reg_wdata;
         if (hit(reg_addr, ADDR_AF_LOW))
            af_lo_d = reg_wdata;
         if (hit(reg_addr, ADDR_ADJ))
            adj_d = reg_wdata;
         if (hit(reg_addr, ADDR_BRT_LOW))
            low_d = reg_wdata[2:0];
         if (hit(reg_addr, ADDR_BRT_HIGH))
         begin
            high_d = reg_wdata;
            reg_code_d = {reg_wdata, low_q};
         end
      end
   end
   // -------------------------------------------------------------
   // brightness source selection
   // -------------------------------------------------------------
   ramp_if rif ();
   logic [10:0] duty_code;
   bright_mode_t mode;
   logic [10:0] bright;
   logic [10:0] target;
   duty_meter #(
      .CODE_W(CODE_W)
   ) u_duty (
      .core_clk(core_clk),
      .nrst(nrst),
      .pwm_in(pwm_in),
      .duty_code_q(duty_code)
   );
   code_ramper #(
      .TIMER_W(16),
      .BASE_CYCLES(RAMP_BASE_CYCLES)
   ) u_ramp (
      .core_clk(core_clk),
      .nrst(nrst),
      .rif(rif)
   );
   always_comb
   begin
      mode = bright_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
      case (mode)
         MODE_REG:
            target = reg_code_q;
         MODE_PWM:
            target = duty_code;
         MODE_MUL_RAMP:
            target = scale_by_duty(reg_code_q, duty_code);
         MODE_RAMP_MUL:
            target = reg_code_q;
         default:
            target = reg_code_q;
      endcase
      // duty applied after the ramper, so duty changes bypass ramping
      if (mode == MODE_RAMP_MUL)
         bright = scale_by_duty(rif.level, duty_code);
      else
         bright = rif.level;
   end
   assign rif.target = target;
   assign rif.rate = ctrl_q[CTRL_RATE_LSB +: 3];
   // -------------------------------------------------------------
   // backlight reduction
   // -------------------------------------------------------------
   logic reduce_active;
   logic [10:0] reduce_code;
   logic [10:0] led_code_d;
   // ramper keeps tracking underneath, so release returns to the live target
   always_comb
   begin
      reduce_active = backlight_reduce_input ^ ctrl_q[CTRL_POL_BIT];
      reduce_code = {adj_q, 3'h0};
      if (reduce_active && (reduce_code < bright))
         led_code_d = reduce_code;
      else
         led_code_d = bright;
   end
   // -------------------------------------------------------------
   // boost switching frequency
   // -------------------------------------------------------------
   logic auto_mode;
   sw_freq_t sw_freq_d;
   logic dmax_half_d;
   logic freq_shift_d;
   logic min_inductor_d;
   // evaluated every cycle, so any threshold or high byte change is seen
   always_comb
   begin
      auto_mode = (af_hi_q != 8'h00) || (af_lo_q != 8'h00);
      if (!auto_mode)
         sw_freq_d = boost_q[BOOST_FREQ_BIT] ? FREQ_1M : FREQ_500K;
      else if (high_q >= af_hi_q)
         sw_freq_d = FREQ_1M;
      else if (high_q < af_lo_q)
         sw_freq_d = FREQ_250K;
      else
         sw_freq_d = FREQ_500K;
      dmax_half_d = (sw_freq_d == FREQ_250K);
      freq_shift_d = boost_q[BOOST_SHIFT_BIT];
      min_inductor_d = boost_q[BOOST_MIN_IND_BIT];
   end
   // -------------------------------------------------------------
   // readback
   // -------------------------------------------------------------
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_BRT_CTRL: rdata_d = ctrl_q;
            ADDR_BOOST: rdata_d = boost_q;
            ADDR_AF_HIGH: rdata_d = af_hi_q;
            ADDR_AF_LOW: rdata_d = af_lo_q;
            ADDR_ADJ: rdata_d = adj_q;
            ADDR_BRT_LOW: rdata_d = {5'h00, low_q};
            ADDR_BRT_HIGH: rdata_d = high_q;
            ADDR_STATUS: rdata_d = led_code_q[10:3];
            default: rdata_d = 8'h00;
         endcase
      end
   end
   // -------------------------------------------------------------
   // state registers
   // -------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= REG_RESET;
         boost_q <= REG_RESET;
         af_hi_q <= REG_RESET;
         af_lo_q <= REG_RESET;
         adj_q <= REG_RESET;
         low_q <= LOW_RESET;
         high_q <= REG_RESET;
         reg_code_q <= '0;
         reg_rdata_q <= REG_RESET;
         led_code_q <= '0;
         sw_freq_q <= FREQ_500K;
         freq_shift_q <= 1'b0;
         dmax_half_q <= 1'b0;
         min_inductor_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         boost_q <= boost_d;
         af_hi_q <= af_hi_d;
         af_lo_q <= af_lo_d;
         adj_q <= adj_d;
         low_q <= low_d;
         high_q <= high_d;
         reg_code_q <= reg_code_d;
         reg_rdata_q <= rdata_d;
         led_code_q <= led_code_d;
         sw_freq_q <= sw_freq_d;
         freq_shift_q <= freq_shift_d;
         dmax_half_q <= dmax_half_d;
         min_inductor_q <= min_inductor_d;
      end
   end
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_code_latch_high: assert property (!(reg_wr && reg_addr == ADDR_BRT_HIGH) |=> $stable(reg_code_q)) else $error("code changed without high byte write");
   chk_code_takes_low: assert property (reg_wr && reg_addr == ADDR_BRT_HIGH |=> reg_code_q == {$past(reg_wdata), $past(low_q)}) else $error("latched code wrong");
   chk_pwm_only_target: assert property (mode == MODE_PWM |-> rif.target == duty_code) else $error("pwm mode used register code");
   chk_mul_target: assert property (mode == MODE_MUL_RAMP |-> rif.target == scale_by_duty(reg_code_q, duty_code)) else $error("multiply target wrong");
   chk_ramp_then_mul: assert property (mode == MODE_RAMP_MUL && !reduce_active |=> led_code_q == scale_by_duty($past(rif.level), $past(duty_code))) else $error("ramper output not scaled");
   chk_reduce_fast: assert property (reduce_active && reduce_code < bright |=> led_code_q == {$past(adj_q), 3'h0}) else $error("reduction late or wrong");
   chk_reduce_lowers: assert property (reduce_active |=> led_code_q <= $past(bright)) else $error("reduction raised current");
   chk_release_restore: assert property ($fell(reduce_active) |-> ##1 led_code_q == $past(bright)) else $error("release did not restore target");
   chk_polarity_sel: assert property (ctrl_q[CTRL_POL_BIT] && !backlight_reduce_input && {adj_q, 3'h0} < bright |=> led_code_q == {$past(adj_q), 3'h0}) else $error("active low polarity ignored");
   chk_fixed_freq: assert property (!auto_mode |=> sw_freq_q == ($past(boost_q[BOOST_FREQ_BIT]) ? FREQ_1M : FREQ_500K)) else $error("fixed frequency wrong");
   chk_auto_high: assert property (auto_mode && high_q >= af_hi_q |=> sw_freq_q == FREQ_1M) else $error("auto high band wrong");
   chk_auto_low: assert property (auto_mode && high_q < af_lo_q && high_q < af_hi_q |=> sw_freq_q == FREQ_250K && dmax_half_q) else $error("auto low band wrong");
   chk_low_only_auto: assert property (sw_freq_q == FREQ_250K |-> $past(auto_mode)) else $error("250 kHz outside auto mode");
   chk_shift_follow: assert property (reg_wr && reg_addr == ADDR_BOOST |-> ##2 freq_shift_q == $past(reg_wdata[BOOST_SHIFT_BIT], 2)) else $error("shift bit not applied");
endmodule
`default_nettype wire

//--- code_ramper.sv
// ramper stepping its level one code per programmed interval, jumping straight to the target at rate 0
`default_nettype none
module code_ramper #(
   parameter int TIMER_W = 16,
   parameter int BASE_CYCLES = backlight_pkg::RAMP_BASE_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // control side
   ramp_if.ramper rif
);
   import backlight_pkg::*;
   if (BASE_CYCLES < 1 || (BASE_CYCLES << 6) >= (1 << TIMER_W))
      $error("ramp base does not fit the timer");
   logic [10:0] level_q, level_d;
   logic [TIMER_W-1:0] tmr_q, tmr_d;
   function automatic logic [TIMER_W-1:0] interval(input logic [2:0] rate);
      return TIMER_W'(BASE_CYCLES) << (rate - 3'h1);
   endfunction
   // first step is taken at once, so a move of n codes lasts (n-1) intervals
   always_comb
   begin
      level_d = level_q;
      tmr_d = tmr_q;
      if (tmr_q != '0)
         tmr_d = tmr_q - 1'b1;
      else if (level_q != rif.target)
      begin
         if (rif.rate == 3'h0)
            level_d = rif.target;
         else
         begin
            level_d = (level_q < rif.target) ? level_q + 11'h1 : level_q - 11'h1;
            tmr_d = interval(rif.rate) - 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         level_q <= '0;
         tmr_q <= '0;
      end
      else
      begin
         level_q <= level_d;
         tmr_q <= tmr_d;
      end
   end
   assign rif.level = level_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence seq_waiting;
      tmr_q != '0;
   endsequence
   chk_ramp_single_step: assert property ((rif.rate != 3'h0) |=> ($past(level_q) - level_q == 11'h1) || (level_q - $past(level_q) == 11'h1) || $stable(level_q)) else $error("ramper jumped more than one code");
   chk_ramp_hold_wait: assert property (seq_waiting |=> $stable(level_q)) else $error("ramper stepped before its interval");
   chk_ramp_stop: assert property ((level_q == rif.target) && $stable(rif.target) |=> $stable(level_q)) else $error("ramper moved at target");
endmodule
`default_nettype wire

//--- duty_meter.sv
// measures pwm duty cycle over a fixed sampling window
`default_nettype none
module duty_meter #(
   parameter int CODE_W = 11
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // pin and result
   input wire logic pwm_in,
   output var logic [CODE_W-1:0] duty_code_q
);
   import backlight_pkg::*;
   if (CODE_W < 4 || CODE_W > 16)
      $error("duty code width out of range");
   logic [CODE_W-1:0] win_q, win_d;
   logic [CODE_W:0] high_q, high_d;
   logic [CODE_W-1:0] duty_d;
   logic [CODE_W:0] total;
   // window of 2^CODE_W samples gives one sample per code
   always_comb
   begin
      total = high_q + {{CODE_W{1'b0}}, pwm_in};
      win_d = win_q + 1'b1;
      high_d = total;
      duty_d = duty_code_q;
      if (&win_q)
      begin
         high_d = '0;
         duty_d = total[CODE_W] ? {CODE_W{1'b1}} : total[CODE_W-1:0];
      end
   end
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         win_q <= '0;
         high_q <= '0;
         duty_code_q <= '0;
      end
      else
      begin
         win_q <= win_d;
         high_q <= high_d;
         duty_code_q <= duty_d;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_duty_update_edge: assert property (!(&$past(win_q)) |-> $stable(duty_code_q)) else $error("duty code changed mid window");
endmodule
`default_nettype wire

//--- host_model.sv
// host-side model driving the register port and the two pins
`default_nettype none
module host_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // register port
   output var logic [7:0] reg_addr,
   output var logic [7:0] reg_wdata,
   output var logic reg_wr,
   output var logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   // pins
   output var logic pwm_in,
   output var logic backlight_reduce_input
);
   timeunit 1ns;
   timeprecision 1ps;
   import backlight_pkg::*;
   logic [7:0] pwm_cnt;
   int pwm_high;
   // set by the bench to read a register in the same cycle that writes it
   logic rd_with_wr;
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      pwm_in = 1'b0;
      backlight_reduce_input = 1'b0;
      pwm_cnt = 8'h00;
      pwm_high = 0;
      rd_with_wr = 1'b0;
   end
   // --------------------------------------------------------------
   // pwm source: period 256 divides the 2048-cycle window evenly
   // --------------------------------------------------------------
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pwm_cnt <= 8'h00;
      else
         pwm_cnt <= pwm_cnt + 8'h01;
      pwm_in <= nrst && ({1'b0, pwm_cnt} < 9'(pwm_high));
   end
   // --------------------------------------------------------------
   // register cycles
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= rd_with_wr;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // released bus must not keep showing the old value
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata_q;
   endtask
   task automatic set_code(input logic [10:0] c);
      wr(ADDR_BRT_LOW, {5'h00, c[2:0]});
      wr(ADDR_BRT_HIGH, c[10:3]);
   endtask
   task automatic set_reduce(input logic v);
      @(posedge core_clk);
      backlight_reduce_input <= v;
   endtask
endmodule
`default_nettype wire

//--- ramp_if.sv
// link between brightness control and the ramper
`default_nettype none
interface ramp_if;
   logic [10:0] target;
   logic [10:0] level;
   logic [2:0] rate;
   modport ctrl (output target, output rate, input level);
   modport ramper (input target, input rate, output level);
endinterface
`default_nettype wire

//--- testbench.sv
// self-checking bench of the brightness path
`default_nettype none
`define CHK(g, e) check_eq(11'(g), 11'(e))
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import backlight_pkg::*;
   logic core_clk, nrst, reg_wr, reg_rd, pwm_in, backlight_reduce_input;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
   logic [10:0] led_code_q;
   sw_freq_t sw_freq_q;
   logic freq_shift_q, dmax_half_q, min_inductor_q;
   int miscompares = 0;
   int cmp_count = 0;
   logic [7:0] addrs [7] = '{ADDR_BRT_CTRL, ADDR_BOOST, ADDR_AF_HIGH, ADDR_AF_LOW, ADDR_ADJ,
                             ADDR_BRT_LOW, ADDR_BRT_HIGH};
   logic [7:0] vals [7];
   int pwm_tab [3] = '{64, 200, 256};
   brightness_path brightness_path_inst (.core_clk(core_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .pwm_in(pwm_in), .backlight_reduce_input(backlight_reduce_input),
      .led_code_q(led_code_q), .sw_freq_q(sw_freq_q), .freq_shift_q(freq_shift_q),
      .dmax_half_q(dmax_half_q), .min_inductor_q(min_inductor_q));
   host_model host_model_inst (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .pwm_in(pwm_in), .backlight_reduce_input(backlight_reduce_input));
   // --------------------------------------------------------------
   // expectations and helpers
   // --------------------------------------------------------------
   function automatic logic [10:0] scale(input logic [10:0] c, input logic [10:0] d);
      logic [22:0] p;
      p = c * ({1'b0, d} + 12'h001);
      return p[21:11];
   endfunction
   function automatic logic [2:0] exp_freq(input logic [7:0] msb, hi, lo, input logic fbit);
      if (hi == 8'h00 && lo == 8'h00)
         return fbit ? 3'h4 : 3'h2;
      if (msb >= hi)
         return 3'h4;
      if (msb < lo)
         return 3'h1;
      return 3'h2;
   endfunction
   task automatic check_eq(input logic [10:0] g, input logic [10:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial
   begin
      repeat (60000) @(posedge core_clk);
      miscompares++;
      report_and_stop();
   end
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial
   begin
      logic [7:0] rv;
      logic [10:0] bright, exp_led, prev;
      int steps, t0, last;
      nrst = 1'b0;
      void'($urandom(32'h0000_f2ed));
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      cyc(1);
      `CHK(led_code_q, 11'h000);
      `CHK(sw_freq_q, 3'h2);
      foreach (addrs[i])
      begin
         host_model_inst.rd(addrs[i], rv);
         `CHK(rv, REG_RESET);
      end
      // random setups: polarity, boost bits, thresholds, adjust and code together
      repeat (12)
      begin
         foreach (addrs[i])
         begin
            vals[i] = 8'($urandom());
            if (i == 0)
               vals[i] &= 8'h01;
            host_model_inst.wr(addrs[i], vals[i]);
         end
         host_model_inst.wr(ADDR_STATUS, 8'hff);
         host_model_inst.wr(8'h20, 8'hff);
         cyc(4);
         foreach (addrs[i])
         begin
            host_model_inst.rd(addrs[i], rv);
            `CHK(rv, (i == 5) ? {5'h00, vals[i][2:0]} : vals[i]);
         end
         bright = {vals[6], vals[5][2:0]};
         exp_led = (vals[0][0] && {vals[4], 3'h0} < bright) ? {vals[4], 3'h0} : bright;
         `CHK(led_code_q, exp_led);
         host_model_inst.rd(ADDR_STATUS, rv);
         `CHK(rv, exp_led[10:3]);
         host_model_inst.rd(8'h20, rv);
         `CHK(rv, 8'h00);
         `CHK(sw_freq_q, exp_freq(vals[6], vals[2], vals[3], vals[1][5]));
         `CHK(dmax_half_q, exp_freq(vals[6], vals[2], vals[3], vals[1][5]) == 3'h1);
         `CHK(freq_shift_q, vals[1][6]);
         `CHK(min_inductor_q, vals[1][4]);
      end
      // threshold boundaries and the fixed frequencies with auto mode off
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h00);
      for (int k = 0; k < 5; k++)
      begin
         vals[2] = (k < 3) ? 8'h40 : 8'h00;
         vals[3] = (k < 3) ? 8'h20 : 8'h00;
         vals[6] = (k == 0) ? 8'h40 : (k == 1) ? 8'h1f : 8'h20;
         host_model_inst.wr(ADDR_BOOST, (k == 4) ? 8'h20 : 8'h00);
         host_model_inst.wr(ADDR_AF_HIGH, vals[2]);
         host_model_inst.wr(ADDR_AF_LOW, vals[3]);
         host_model_inst.wr(ADDR_BRT_HIGH, vals[6]);
         cyc(3);
         `CHK(sw_freq_q, exp_freq(vals[6], vals[2], vals[3], k == 4));
      end
      // reduction applied at once under the fastest ramp rate (rate 1), then released
      // read and write together: the read returns the value held before the write
      host_model_inst.rd_with_wr = 1'b1;
      host_model_inst.wr(ADDR_ADJ, 8'h10);
      host_model_inst.rd_with_wr = 1'b0;
      cyc(1);
      `CHK(reg_rdata_q, vals[4]);
      host_model_inst.set_code(11'h400);
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h02);
      cyc(3);
      host_model_inst.set_reduce(1'b1);
      cyc(2);
      `CHK(led_code_q, 11'h080);
      host_model_inst.set_reduce(1'b0);
      cyc(2);
      `CHK(led_code_q, 11'h400);
      // eight codes at rate 1: seven intervals between first and last step
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h00);
      host_model_inst.set_code(11'h100);
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h02);
      cyc(3);
      host_model_inst.set_code(11'h108);
      prev = 11'h100;
      steps = 0;
      t0 = 0;
      last = 0;
      for (int k = 0; k < 400 && led_code_q !== 11'h108; k++)
      begin
         cyc(1);
         if (led_code_q !== prev)
         begin
            if (steps == 0)
               t0 = k;
            steps++;
            last = k;
         end
         prev = led_code_q;
      end
      `CHK(steps, 8);
      `CHK(last - t0, 7 * RAMP_BASE_CYCLES);
      // pwm only: register code changes must not matter
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h20);
      foreach (pwm_tab[i])
      begin
         host_model_inst.pwm_high = pwm_tab[i];
         host_model_inst.set_code(11'($urandom()));
         cyc(4200);
         `CHK(led_code_q, (pwm_tab[i] * 8 > 2047) ? 2047 : pwm_tab[i] * 8);
      end
      host_model_inst.pwm_high = 128;
      host_model_inst.set_code(11'h444);
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h40);
      cyc(4200);
      `CHK(led_code_q, scale(11'h444, 11'd1024));
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h60);
      cyc(4);
      // slowest ramp: a duty change must still land without stepping
      host_model_inst.wr(ADDR_BRT_CTRL, 8'h6e);
      host_model_inst.pwm_high = 224;
      cyc(4200);
      `CHK(led_code_q, scale(11'h444, 11'd1792));
      report_and_stop();
   end
endmodule
`undef CHK
`default_nettype wire
